//--- rtl/pmir_pkg.sv
package pmir_pkg;

    // Command codes
    localparam logic [7:0] CMD_STORE_ALL = 8'h15;
    localparam logic [7:0] CMD_RESTORE_ALL = 8'h16;
    localparam logic [7:0] CMD_SERIAL = 8'h9E;
    localparam logic [7:0] CMD_DEVICE_CODE = 8'hAD;
    localparam logic [7:0] CMD_REVISION = 8'hAE;
    localparam logic [7:0] CMD_COMP = 8'hB1;

    // Block lengths in bytes
    localparam logic [2:0] SERIAL_BYTES = 3'h3;
    localparam logic [2:0] CODE_BYTES = 3'h6;
    localparam logic [2:0] REV_BYTES = 3'h2;
    localparam logic [2:0] COMP_BYTES = 3'h5;
    localparam int IMAGE_BYTES = 8;
    localparam logic [3:0] IMAGE_LAST = 4'h7;
    localparam logic [3:0] IMAGE_END = 4'h8;

    // Revision word fields
    localparam int REV_UPPER_LSB = 12;
    localparam int REV_MIDDLE_LSB = 8;
    localparam int REV_LOWER_LSB = 0;

    // Compensation field positions
    localparam int CZI_HI_LSB = 24;
    localparam int CZI_LO_LSB = 38;
    localparam int CPI_LSB = 33;
    localparam int CZI_MUL_BIT = 32;
    localparam int RVI_LSB = 26;
    localparam int CZV_HI_LSB = 8;
    localparam int CZV_LO_LSB = 22;
    localparam int CPV_LSB = 17;
    localparam int RVV_LSB = 10;
    localparam int GMV_LSB = 4;
    localparam int GMI_LSB = 0;

    // Reset values
    localparam logic [23:0] SERIAL_RST = 24'h00_0000;
    localparam logic [39:0] COMP_RST = 40'h00_0000_0000;
    localparam logic [15:0] CHECKSUM_RST = 16'h0000;
    localparam logic [7:0] BYTE_RST = 8'h00;

    typedef enum logic [1:0] {
        WALK_IDLE,
        WALK_LOAD,
        WALK_STORE
    } pmir_walk_e;

endpackage

//--- rtl/pmir_nv_image.sv
`timescale 1ns/1ps
`default_nettype none
module pmir_nv_image
    import pmir_pkg::*;
#(
    parameter int WIDTH = 8,
    parameter int DEPTH = IMAGE_BYTES
) (
    // Clock
    input wire logic sys_clk,
    input wire logic rst,
    // Access port
    input wire logic [$clog2(DEPTH)-1:0] addr,
    input wire logic wrEn,
    input wire logic [WIDTH-1:0] wrData,
    output logic [WIDTH-1:0] rdData
);

    // Image contents survive reset
    logic [WIDTH-1:0] mem [DEPTH] = '{default: '0};
    logic [WIDTH-1:0] rdData_r;
    logic [WIDTH-1:0] rdData_nxt;

    if (DEPTH < 2 || WIDTH < 1) begin : g_bad_geometry
        $error("pmir_nv_image: bad geometry");
    end

    always_comb begin
        rdData_nxt = mem[addr];
    end

    always_ff @(posedge sys_clk) begin
        if (wrEn) begin
            mem[addr] <= wrData;
        end
    end

    always_ff @(posedge sys_clk) begin
        if (rst) begin
            rdData_r <= '0;
        end else begin
            rdData_r <= rdData_nxt;
        end
    end

    assign rdData = rdData_r;

endmodule
`default_nettype wire

//--- rtl/pmir_comp_fields.sv
`timescale 1ns/1ps
`default_nettype none
module pmir_comp_fields
    import pmir_pkg::*;
(
    // Clock
    input wire logic sys_clk,
    input wire logic rst,
    // Update
    input wire logic applyEn,
    input wire logic [39:0] applyValue,
    // Current loop
    output logic [3:0] currentIntegratorCapSel,
    output logic [4:0] currentFilterCapSel,
    output logic currentIntegratorCapDoubler,
    output logic [5:0] currentGainResistorSel,
    // Voltage loop, plus the current-loop transconductance select
    output logic [3:0] voltageIntegratorCapSel,
    output logic [4:0] voltageFilterCapSel,
    output logic [5:0] voltageGainResistorSel,
    output logic [1:0] voltageTransconductanceSel,
    output logic [1:0] currentTransconductanceSel
);

    logic [39:0] hw_r;
    logic [39:0] hw_nxt;

    always_comb begin
        hw_nxt = applyEn ? applyValue : hw_r;
    end

    always_ff @(posedge sys_clk) begin
        if (rst) begin
            hw_r <= COMP_RST;
        end else begin
            hw_r <= hw_nxt;
        end
    end

    // Split fields are joined high part first
    assign currentIntegratorCapSel = {hw_r[CZI_HI_LSB +: 2], hw_r[CZI_LO_LSB +: 2]};
    assign currentFilterCapSel = hw_r[CPI_LSB +: 5];
    assign currentIntegratorCapDoubler = hw_r[CZI_MUL_BIT];
    assign currentGainResistorSel = hw_r[RVI_LSB +: 6];
    assign voltageIntegratorCapSel = {hw_r[CZV_HI_LSB +: 2], hw_r[CZV_LO_LSB +: 2]};
    assign voltageFilterCapSel = hw_r[CPV_LSB +: 5];
    assign voltageGainResistorSel = hw_r[RVV_LSB +: 6];
    assign voltageTransconductanceSel = hw_r[GMV_LSB +: 2];
    assign currentTransconductanceSel = hw_r[GMI_LSB +: 2];

endmodule
`default_nettype wire

//--- rtl/pmir_ident_comp_regs.sv
// Function
// - A 24-bit serial number is written and read by block transfers and kept in the stored image.
// - The serial number is part of the stored image whose checksum is reported.
// - A block read of the device code returns six fixed bytes, lowest byte first; no write.
// - A write to a read-only command sets the comm-fault summary and invalid-command flags.
// - The same fault also notifies the host.
// - A block read of the revision returns a fixed 16-bit word with 4/4/8-bit fields.
// - A 40-bit compensation setup is block written and read, loaded from image or pins.
// - A compensation write reaches the loop hardware only while conversion is off.
// - Store-all then restore-all or a supply dip applies the saved compensation.
// - Current-loop fields sit at their fixed bit positions in the setup.
// - Voltage-loop fields sit at their fixed bit positions in the setup.
`timescale 1ns/1ps
`default_nettype none
module pmir_ident_comp_regs
    import pmir_pkg::*;
#(
    // Arbitrary identification values
    parameter logic [47:0] DEVICE_CODE = 48'h5A5A_0000_0001,
    parameter logic [3:0] REV_UPPER = 4'h1,
    parameter logic [3:0] REV_MIDDLE = 4'h0,
    parameter logic [7:0] REV_LOWER = 8'h00
) (
    // Clock
    input wire logic sys_clk,
    input wire logic rst,
    // Command port from the bus front end
    input wire logic cmdStart,
    input wire logic [7:0] cmdCode,
    input wire logic cmdIsWrite,
    input wire logic cmdStop,
    input wire logic wrValid,
    input wire logic [7:0] wrData,
    input wire logic rdReq,
    output logic cmdReady,
    output logic rdValid,
    output logic [7:0] rdData,
    // Converter state
    input wire logic convEnable,
    input wire logic analogSupplyUv,
    input wire logic compFromPins,
    input wire logic [39:0] compPinValue,
    // Fault reporting
    output logic statusByteCmlSet,
    output logic statusCmlIvcSet,
    output logic hostNotify,
    output logic [15:0] storedImageChecksum,
    // Loop hardware
    output logic [3:0] currentIntegratorCapSel,
    output logic [4:0] currentFilterCapSel,
    output logic currentIntegratorCapDoubler,
    output logic [5:0] currentGainResistorSel,
    output logic [3:0] voltageIntegratorCapSel,
    output logic [4:0] voltageFilterCapSel,
    output logic [5:0] voltageGainResistorSel,
    output logic [1:0] voltageTransconductanceSel,
    output logic [1:0] currentTransconductanceSel
);

    localparam logic [15:0] REV_WORD = {REV_UPPER, REV_MIDDLE, REV_LOWER};

    ////////////////////////////////////////////////////////////////////////////////
    // Functions

    function automatic logic [7:0] imageByte(input logic [23:0] ser, input logic [39:0] cmp,
                                             input logic [2:0] idx);
        logic [63:0] img;
        img = {cmp, ser};
        return img[{idx, 3'b000} +: 8];
    endfunction

    function automatic logic [7:0] readByte(input logic [7:0] code, input logic [2:0] idx,
                                            input logic [23:0] ser, input logic [39:0] cmp);
        logic [63:0] data;
        logic [2:0] len;
        data = '0;
        len = 3'h0;
        unique case (code)
            CMD_SERIAL: begin
                data = {40'h00_0000_0000, ser};
                len = SERIAL_BYTES;
            end
            CMD_DEVICE_CODE: begin
                data = {16'h0000, DEVICE_CODE};
                len = CODE_BYTES;
            end
            CMD_REVISION: begin
                data = {48'h0000_0000_0000, REV_WORD};
                len = REV_BYTES;
            end
            CMD_COMP: begin
                data = {24'h00_0000, cmp};
                len = COMP_BYTES;
            end
            default: begin
                data = '0;
                len = 3'h0;
            end
        endcase
        return (idx == 3'h0) ? {5'h00, len} : data[{idx - 3'h1, 3'b000} +: 8];
    endfunction

    function automatic logic [15:0] imageSum(input logic [23:0] ser, input logic [39:0] cmp);
        logic [15:0] s;
        s = CHECKSUM_RST;
        for (int i = 0; i < IMAGE_BYTES; i++) begin
            s = s + {8'h00, imageByte(ser, cmp, 3'(i))};
        end
        return s;
    endfunction

    ////////////////////////////////////////////////////////////////////////////////
    // Supply dip synchroniser

    logic uvMeta_r, uvSync_r, uvPrev_r;

    always_ff @(posedge sys_clk) begin
        if (rst) begin
            uvMeta_r <= 1'b0;
            uvSync_r <= 1'b0;
            uvPrev_r <= 1'b0;
        end else begin
            uvMeta_r <= analogSupplyUv;
            uvSync_r <= uvMeta_r;
            uvPrev_r <= uvSync_r;
        end
    end

    ////////////////////////////////////////////////////////////////////////////////
    // Command handling and image walk

    pmir_walk_e walk_r, walk_nxt;
    logic [3:0] walkIdx_r, walkIdx_nxt;
    logic [15:0] chkAcc_r, chkAcc_nxt, checksum_r, checksum_nxt;
    logic [23:0] serial_r, serial_nxt;
    logic [39:0] comp_r, comp_nxt, wrBuf_r, wrBuf_nxt;
    logic [7:0] curCode_r, curCode_nxt, rdData_r, rdData_nxt;
    logic active_r, active_nxt, curWrite_r, curWrite_nxt;
    logic [2:0] wrCnt_r, wrCnt_nxt, rdIdx_r, rdIdx_nxt;
    logic cmdReady_r, cmdReady_nxt, rdValid_r, rdValid_nxt;
    logic cmlSet_r, cmlSet_nxt, ivcSet_r, ivcSet_nxt, notify_r, notify_nxt;
    logic applyEn;
    logic [39:0] applyValue;
    logic [2:0] memAddr;
    logic memWrEn;
    logic [7:0] memWrData, memRdData;
    logic roWrite, commit;
    logic [63:0] img;

    always_comb begin
        walk_nxt = walk_r;
        walkIdx_nxt = walkIdx_r;
        chkAcc_nxt = chkAcc_r;
        checksum_nxt = checksum_r;
        serial_nxt = serial_r;
        comp_nxt = comp_r;
        wrBuf_nxt = wrBuf_r;
        curCode_nxt = curCode_r;
        curWrite_nxt = curWrite_r;
        active_nxt = active_r;
        wrCnt_nxt = wrCnt_r;
        rdIdx_nxt = rdIdx_r;
        rdValid_nxt = 1'b0;
        rdData_nxt = rdData_r;
        applyEn = 1'b0;
        applyValue = comp_r;
        memAddr = walkIdx_r[2:0];
        memWrEn = 1'b0;
        memWrData = imageByte(serial_r, comp_r, walkIdx_r[2:0]);
        img = {comp_r, serial_r};
        roWrite = cmdStart && cmdReady_r && cmdIsWrite &&
                  (cmdCode == CMD_DEVICE_CODE || cmdCode == CMD_REVISION);
        commit = cmdStop && active_r && curWrite_r;
        // Read-only write flags the fault, data is dropped
        cmlSet_nxt = roWrite;
        ivcSet_nxt = roWrite;
        notify_nxt = roWrite;
        unique case (walk_r)
            WALK_IDLE: begin
                if (cmdStart && cmdReady_r) begin
                    active_nxt = 1'b1;
                    curCode_nxt = cmdCode;
                    curWrite_nxt = cmdIsWrite;
                    wrCnt_nxt = 3'h0;
                    rdIdx_nxt = 3'h0;
                end
                if (wrValid && active_r && curWrite_r && wrCnt_r < COMP_BYTES) begin
                    wrBuf_nxt[{wrCnt_r, 3'b000} +: 8] = wrData;
                    wrCnt_nxt = wrCnt_r + 3'h1;
                end
                if (rdReq && active_r && !curWrite_r) begin
                    rdValid_nxt = 1'b1;
                    rdData_nxt = readByte(curCode_r, rdIdx_r, serial_r, comp_r);
                    rdIdx_nxt = (rdIdx_r == 3'h7) ? rdIdx_r : rdIdx_r + 3'h1;
                end
                if (cmdStop && active_r) begin
                    active_nxt = 1'b0;
                end
                if (commit && curCode_r == CMD_SERIAL && wrCnt_r == SERIAL_BYTES) begin
                    serial_nxt = wrBuf_r[23:0];
                end
                if (commit && curCode_r == CMD_COMP && wrCnt_r == COMP_BYTES) begin
                    comp_nxt = wrBuf_r;
                    applyEn = !convEnable;
                    applyValue = wrBuf_r;
                end
                if (commit && curCode_r == CMD_STORE_ALL && wrCnt_r == 3'h0) begin
                    walk_nxt = WALK_STORE;
                    walkIdx_nxt = 4'h0;
                    chkAcc_nxt = CHECKSUM_RST;
                end else if ((commit && curCode_r == CMD_RESTORE_ALL && wrCnt_r == 3'h0) ||
                             (uvPrev_r && !uvSync_r)) begin
                    walk_nxt = WALK_LOAD;
                    walkIdx_nxt = 4'h0;
                    chkAcc_nxt = CHECKSUM_RST;
                    active_nxt = 1'b0;
                end
            end
            WALK_LOAD: begin
                if (walkIdx_r != 4'h0) begin
                    img[{walkIdx_r[2:0] - 3'h1, 3'b000} +: 8] = memRdData;
                    chkAcc_nxt = chkAcc_r + {8'h00, memRdData};
                end
                serial_nxt = img[23:0];
                comp_nxt = img[63:24];
                walkIdx_nxt = walkIdx_r + 4'h1;
                if (walkIdx_r == IMAGE_END) begin
                    if (compFromPins) begin
                        comp_nxt = compPinValue;
                    end
                    applyEn = 1'b1;
                    applyValue = comp_nxt;
                    checksum_nxt = chkAcc_nxt;
                    walk_nxt = WALK_IDLE;
                end
            end
            WALK_STORE: begin
                memWrEn = 1'b1;
                chkAcc_nxt = chkAcc_r + {8'h00, memWrData};
                walkIdx_nxt = walkIdx_r + 4'h1;
                if (walkIdx_r == IMAGE_LAST) begin
                    checksum_nxt = chkAcc_nxt;
                    walk_nxt = WALK_IDLE;
                end
            end
        endcase
        // Host is held off while the image is walked
        cmdReady_nxt = (walk_nxt == WALK_IDLE);
    end

    always_ff @(posedge sys_clk) begin
        if (rst) begin
            walk_r <= WALK_LOAD;
            walkIdx_r <= 4'h0;
            chkAcc_r <= CHECKSUM_RST;
            checksum_r <= CHECKSUM_RST;
            serial_r <= SERIAL_RST;
            comp_r <= COMP_RST;
            wrBuf_r <= COMP_RST;
            curCode_r <= BYTE_RST;
            curWrite_r <= 1'b0;
            active_r <= 1'b0;
            wrCnt_r <= 3'h0;
            rdIdx_r <= 3'h0;
            cmdReady_r <= 1'b0;
            rdValid_r <= 1'b0;
            rdData_r <= BYTE_RST;
            cmlSet_r <= 1'b0;
            ivcSet_r <= 1'b0;
            notify_r <= 1'b0;
        end else begin
            walk_r <= walk_nxt;
            walkIdx_r <= walkIdx_nxt;
            chkAcc_r <= chkAcc_nxt;
            checksum_r <= checksum_nxt;
            serial_r <= serial_nxt;
            comp_r <= comp_nxt;
            wrBuf_r <= wrBuf_nxt;
            curCode_r <= curCode_nxt;
            curWrite_r <= curWrite_nxt;
            active_r <= active_nxt;
            wrCnt_r <= wrCnt_nxt;
            rdIdx_r <= rdIdx_nxt;
            cmdReady_r <= cmdReady_nxt;
            rdValid_r <= rdValid_nxt;
            rdData_r <= rdData_nxt;
            cmlSet_r <= cmlSet_nxt;
            ivcSet_r <= ivcSet_nxt;
            notify_r <= notify_nxt;
        end
    end

    assign cmdReady = cmdReady_r;
    assign rdValid = rdValid_r;
    assign rdData = rdData_r;
    assign statusByteCmlSet = cmlSet_r;
    assign statusCmlIvcSet = ivcSet_r;
    assign hostNotify = notify_r;
    assign storedImageChecksum = checksum_r;

    ////////////////////////////////////////////////////////////////////////////////
    // Stored image and loop hardware

    pmir_nv_image #(
        .WIDTH(8),
        .DEPTH(IMAGE_BYTES)
    ) u_image (
        .sys_clk(sys_clk),
        .rst(rst),
        .addr(memAddr),
        .wrEn(memWrEn),
        .wrData(memWrData),
        .rdData(memRdData)
    );

    pmir_comp_fields u_fields (
        .sys_clk(sys_clk),
        .rst(rst),
        .applyEn(applyEn),
        .applyValue(applyValue),
        .currentIntegratorCapSel(currentIntegratorCapSel),
        .currentFilterCapSel(currentFilterCapSel),
        .currentIntegratorCapDoubler(currentIntegratorCapDoubler),
        .currentGainResistorSel(currentGainResistorSel),
        .voltageIntegratorCapSel(voltageIntegratorCapSel),
        .voltageFilterCapSel(voltageFilterCapSel),
        .voltageGainResistorSel(voltageGainResistorSel),
        .voltageTransconductanceSel(voltageTransconductanceSel),
        .currentTransconductanceSel(currentTransconductanceSel)
    );

    ////////////////////////////////////////////////////////////////////////////////
    // Checks

    default clocking cb @(posedge sys_clk); endclocking
    default disable iff (rst);

    sequence s_ro_write;
        cmdStart && cmdReady_r && cmdIsWrite &&
            (cmdCode == CMD_DEVICE_CODE || cmdCode == CMD_REVISION);
    endsequence

    sequence s_comp_commit;
        commit && walk_r == WALK_IDLE && curCode_r == CMD_COMP && wrCnt_r == COMP_BYTES;
    endsequence

    sequence s_read_at(logic [7:0] code, logic [2:0] idx);
        rdReq && active_r && !curWrite_r && walk_r == WALK_IDLE &&
            curCode_r == code && rdIdx_r == idx;
    endsequence

    a_serial_commit: assert property (commit && walk_r == WALK_IDLE &&
        curCode_r == CMD_SERIAL && wrCnt_r == SERIAL_BYTES |=>
        serial_r == $past(wrBuf_r[23:0]) && rdValid_r == 1'b0)
        else $error("serial write not committed");

    a_store_checksum: assert property (walk_r == WALK_STORE && walkIdx_r == IMAGE_LAST |=>
        checksum_r == imageSum(serial_r, comp_r) && cmdReady_r)
        else $error("checksum does not match stored image");

    a_code_low_byte: assert property (s_read_at(CMD_DEVICE_CODE, 3'h1) |=>
        rdValid_r && rdData_r == DEVICE_CODE[7:0])
        else $error("device code byte 0 wrong");

    a_ro_fault_flags: assert property (s_ro_write |=>
        statusByteCmlSet && statusCmlIvcSet ##1 !statusCmlIvcSet)
        else $error("read-only write did not raise fault");

    a_fault_notify: assert property (s_ro_write |=> hostNotify ##1 !hostNotify)
        else $error("fault not notified");

    a_rev_high_byte: assert property (s_read_at(CMD_REVISION, 3'h2) |=>
        rdData_r[7:4] == REV_UPPER && rdData_r[3:0] == REV_MIDDLE)
        else $error("revision high byte wrong");

    a_comp_apply: assert property (s_comp_commit ##0 !convEnable |=>
        currentFilterCapSel == $past(wrBuf_r[CPI_LSB +: 5]) &&
        currentIntegratorCapSel == {$past(wrBuf_r[25:24]), $past(wrBuf_r[39:38])})
        else $error("compensation not applied");

    a_comp_blocked: assert property (s_comp_commit ##0 convEnable |=>
        $stable({currentGainResistorSel, voltageGainResistorSel, currentFilterCapSel}) &&
        comp_r == $past(wrBuf_r))
        else $error("compensation reached loop while converting");

    a_voltage_fields: assert property (s_comp_commit ##0 !convEnable |=>
        voltageGainResistorSel == $past(wrBuf_r[15:10]) &&
        voltageIntegratorCapSel == {$past(wrBuf_r[9:8]), $past(wrBuf_r[23:22])})
        else $error("voltage field placement wrong");

    a_reload_bound: assert property (walk_r == WALK_IDLE && walk_nxt == WALK_LOAD |=>
        !cmdReady_r ##9 cmdReady_r)
        else $error("reload did not finish");

    a_poweron_load: assert property ($past(rst) |-> !cmdReady_r ##[8:10] cmdReady_r)
        else $error("power-on load timing wrong");

endmodule
`default_nettype wire

//--- verif/pmir_host_model.sv
`timescale 1ns/1ps
`default_nettype none
module pmir_host_model
    import pmir_pkg::*;
(
    // Clock
    input wire logic sys_clk,
    // Command port
    output logic cmdStart,
    output logic [7:0] cmdCode,
    output logic cmdIsWrite,
    output logic cmdStop,
    output logic wrValid,
    output logic [7:0] wrData,
    output logic rdReq,
    input wire logic cmdReady,
    input wire logic rdValid,
    input wire logic [7:0] rdData
);
    int errs = 0;
    initial begin
        {cmdStart, cmdCode, cmdIsWrite, cmdStop, wrValid, wrData, rdReq} = '0;
    end
    ////////////////////////////////////////////////////////////////////////
    // Waits for the device to take commands, then opens a transfer
    task automatic open(input logic [7:0] code, input logic wr);
        int n;
        n = 0;
        while (cmdReady !== 1'b1 && n < 40) begin
            @(posedge sys_clk);
            #1;
            n++;
        end
        if (cmdReady !== 1'b1) begin
            errs++;
            $display("ERROR cmdReady expected 1 seen %b", cmdReady);
        end
        cmdStart = 1'b1;
        cmdCode = code;
        cmdIsWrite = wr;
        @(posedge sys_clk);
        #1;
        cmdStart = 1'b0;
    endtask
    // A walk pulls cmdReady low at the stop edge; two idle cycles follow
    task automatic close();
        cmdStop = 1'b1;
        @(posedge sys_clk);
        #1;
        cmdStop = 1'b0;
        repeat (2) @(posedge sys_clk);
        #1;
    endtask
    task automatic wr(input logic [7:0] code, input int nb, input logic [47:0] v);
        open(code, 1'b1);
        for (int k = 0; k < nb; k++) begin
            wrValid = 1'b1;
            wrData = v[8*k +: 8];
            @(posedge sys_clk);
            #1;
        end
        wrValid = 1'b0;
        wrData = ~wrData;
        close();
    endtask
    task automatic rd(input logic [7:0] code, input int nb, output logic [7:0] cnt,
                      output logic [47:0] v);
        open(code, 1'b0);
        v = '0;
        for (int k = 0; k <= nb; k++) begin
            rdReq = 1'b1;
            @(posedge sys_clk);
            #1;
            rdReq = 1'b0;
            if (rdValid !== 1'b1) begin
                errs++;
                $display("ERROR rdValid expected 1 seen %b", rdValid);
            end
            if (k == 0) cnt = rdData;
            else v[8*(k-1) +: 8] = rdData;
            @(posedge sys_clk);
            #1;
        end
        close();
    endtask
endmodule
`default_nettype wire

//--- verif/testbench.sv
`timescale 1ns/1ps
`default_nettype none
module testbench
    import pmir_pkg::*;
;
    localparam logic [47:0] CODE = 48'hC3C3_0F0F_1234; // Arbitrary
    localparam logic [39:0] C1 = 40'hA5_9C3E_5A33;
    localparam logic [39:0] C2 = 40'h5A_63C1_A4CC;
    localparam logic [39:0] C3 = 40'hF0_0FF0_0F11;
    localparam logic [23:0] SER = 24'hA5_3C96;
    logic sys_clk = 0, rst = 1, convEnable = 0, analogSupplyUv = 0, compFromPins = 0;
    logic cmdStart, cmdIsWrite, cmdStop, wrValid, rdReq, cmdReady, rdValid, dbl;
    logic statusByteCmlSet, statusCmlIvcSet, hostNotify;
    logic [7:0] cmdCode, wrData, rdData, cnt;
    logic [15:0] storedImageChecksum;
    logic [47:0] v;
    logic [3:0] cic, vic;
    logic [4:0] cfc, vfc;
    logic [5:0] cgr, vgr;
    logic [1:0] vt, ct;
    int num_errors = 0, n_compared = 0, nFault = 0;
    ////////////////////////////////////////////////////////////////////////
    pmir_ident_comp_regs #(.DEVICE_CODE(CODE), .REV_UPPER(4'h2), .REV_MIDDLE(4'h3),
        .REV_LOWER(8'h45)) DUT (.sys_clk, .rst, .cmdStart, .cmdCode, .cmdIsWrite,
        .cmdStop, .wrValid, .wrData, .rdReq, .cmdReady, .rdValid, .rdData, .convEnable,
        .analogSupplyUv, .compFromPins, .compPinValue(C1),
        .statusByteCmlSet, .statusCmlIvcSet, .hostNotify, .storedImageChecksum,
        .currentIntegratorCapSel(cic), .currentFilterCapSel(cfc),
        .currentIntegratorCapDoubler(dbl), .currentGainResistorSel(cgr),
        .voltageIntegratorCapSel(vic), .voltageFilterCapSel(vfc),
        .voltageGainResistorSel(vgr), .voltageTransconductanceSel(vt),
        .currentTransconductanceSel(ct));
    pmir_host_model host (.sys_clk, .cmdStart, .cmdCode, .cmdIsWrite, .cmdStop,
        .wrValid, .wrData, .rdReq, .cmdReady, .rdValid, .rdData);
    initial begin
        forever #25 sys_clk = ~sys_clk;
    end
    always @(posedge sys_clk) begin
        if (statusByteCmlSet === 1'b1 && statusCmlIvcSet === 1'b1 && hostNotify === 1'b1)
            nFault++;
    end
    ////////////////////////////////////////////////////////////////////////
    task automatic chk(input string nm, input logic [47:0] e, input logic [47:0] g);
        n_compared++;
        if (g !== e) begin
            num_errors++;
            $display("ERROR %s expected %h seen %h", nm, e, g);
        end
    endtask
    // Loop fields checked as one concatenated word
    task automatic fld(input logic [39:0] c);
        chk("fields", {c[25:24], c[39:38], c[37:33], c[32], c[31:26], c[9:8], c[23:22],
            c[21:17], c[15:10], c[5:4], c[1:0]}, {cic, cfc, dbl, cgr, vic, vfc, vgr, vt, ct});
    endtask
    function automatic logic [15:0] csum(input logic [63:0] im);
        csum = 16'h0000;
        for (int k = 0; k < 8; k++) csum += im[8*k +: 8];
    endfunction
    task automatic end_of_test();
        num_errors += host.errs;
        $display("Compared %0d, mismatches %0d", n_compared, num_errors);
        if (num_errors == 0 && n_compared > 0) $display("Test passed");
        else $display("Test failed");
        $finish;
    endtask
    initial begin
        #200_000;
        num_errors++;
        end_of_test();
    end
    ////////////////////////////////////////////////////////////////////////
    initial begin
        repeat (20) @(posedge sys_clk);
        #1;
        rst = 0;
        @(posedge sys_clk);
        #1;
        chk("ready_low", 0, cmdReady);
        host.rd(CMD_SERIAL, 3, cnt, v);
        chk("ser_cnt", 3, cnt);
        chk("ser_boot", 0, v);
        host.wr(CMD_SERIAL, 3, {24'h0, SER});
        host.rd(CMD_SERIAL, 3, cnt, v);
        chk("ser_val", SER, v);
        $display("Test serial done");
        host.rd(CMD_DEVICE_CODE, 6, cnt, v);
        chk("code_cnt", 6, cnt);
        chk("code_val", CODE, v);
        host.rd(CMD_REVISION, 2, cnt, v);
        chk("rev_cnt", 2, cnt);
        chk("rev_val", 16'h2345, v);
        host.wr(CMD_DEVICE_CODE, 0, 48'h0);
        host.wr(CMD_REVISION, 0, 48'h0);
        chk("faults", 2, nFault);
        host.rd(CMD_DEVICE_CODE, 6, cnt, v);
        chk("code_kept", CODE, v);
        $display("Test ident done");
        host.wr(CMD_COMP, 5, {8'h0, C1});
        fld(C1);
        convEnable = 1;
        host.wr(CMD_COMP, 5, {8'h0, C2});
        fld(C1);
        host.rd(CMD_COMP, 5, cnt, v);
        chk("comp_cnt", 5, cnt);
        chk("comp_val", C2, v);
        $display("Test comp done");
        host.wr(CMD_STORE_ALL, 0, 48'h0);
        host.rd(CMD_COMP, 5, cnt, v);
        chk("checksum", csum({C2, SER}), storedImageChecksum);
        host.wr(CMD_RESTORE_ALL, 0, 48'h0);
        host.rd(CMD_SERIAL, 3, cnt, v);
        chk("ser_restored", SER, v);
        fld(C2);
        host.wr(CMD_COMP, 5, {8'h0, C3});
        fld(C2);
        host.wr(CMD_STORE_ALL, 0, 48'h0);
        host.rd(CMD_COMP, 5, cnt, v);
        analogSupplyUv = 1;
        repeat (5) @(posedge sys_clk);
        #1;
        analogSupplyUv = 0;
        repeat (20) @(posedge sys_clk);
        #1;
        host.rd(CMD_COMP, 5, cnt, v);
        chk("comp_reload", C3, v);
        fld(C3);
        compFromPins = 1;
        host.wr(CMD_RESTORE_ALL, 0, 48'h0);
        host.rd(CMD_COMP, 5, cnt, v);
        chk("comp_pins", C1, v);
        chk("load_sum", csum({C3, SER}), storedImageChecksum);
        fld(C1);
        $display("Test reload done");
        end_of_test();
    end
endmodule
`default_nettype wire
